/* pkg/gpp_pkg.sv */
package gpp_pkg;

   // ****************************************************************
   // geometry
   // ****************************************************************
   localparam int          NUM_PORTS   = 2;
   localparam int          PORT_W      = 8;
   localparam int          IDX_W       = 4;
   localparam int          PORT_A      = 0;
   localparam int          PORT_D      = 1;
   localparam int          PORT_SEL_BIT = 6;

   // ****************************************************************
   // register indices within a port; byte address is index * 4
   // ****************************************************************
   localparam logic [3:0]  IDX_PIN_LEVEL   = 4'h0;
   localparam logic [3:0]  IDX_DIRECTION   = 4'h1;
   localparam logic [3:0]  IDX_OUT_LATCH   = 4'h2;
   localparam logic [3:0]  IDX_ANALOG_SEL  = 4'h3;
   localparam logic [3:0]  IDX_PULLUP_EN   = 4'h4;
   localparam logic [3:0]  IDX_OPEN_DRAIN  = 4'h5;
   localparam logic [3:0]  IDX_SLEW_LIMIT  = 4'h6;
   localparam logic [3:0]  IDX_IN_THRESH   = 4'h7;
   localparam logic [3:0]  IDX_PERIPH_SEL  = 4'h8;

   // ****************************************************************
   // implemented-bit masks, index 0 is port a, index 1 is port d
   // ****************************************************************
   localparam logic [1:0][7:0] IMPL_MASK   = {8'hFF, 8'hDF};
   localparam logic [1:0][7:0] DIR_FILL    = {8'h00, 8'h20};
   localparam logic [1:0][7:0] FULL_MASK   = {8'hFF, 8'hFF};

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0]  RST_OUT_LATCH   = 8'h00;
   localparam logic [7:0]  RST_DIRECTION   = 8'hFF;
   localparam logic [7:0]  RST_ANALOG_SEL  = 8'hFF;
   localparam logic [7:0]  RST_PULLUP_EN   = 8'h00;
   localparam logic [7:0]  RST_OPEN_DRAIN  = 8'h00;
   localparam logic [7:0]  RST_SLEW_LIMIT  = 8'hFF;
   localparam logic [7:0]  RST_IN_THRESH   = 8'h00;
   localparam logic [7:0]  RST_PERIPH_SEL  = 8'h00;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [7:0] out_latch;
      logic [7:0] direction;
      logic [7:0] analog_sel;
      logic [7:0] pullup_en;
      logic [7:0] open_drain;
      logic [7:0] slew_limit;
      logic [7:0] in_thresh;
      logic [7:0] periph_sel;
   } gpp_ctrl_type;

   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] i2c_mode;
      logic [7:0] analog_out_en;
   } gpp_periph_type;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pullup_on;
      logic [7:0] slew_limited;
      logic [7:0] ttl_select;
      logic [7:0] in_buf_en;
   } gpp_pad_type;

endpackage : gpp_pkg

/* src/gpp_sync.sv */
`timescale 1ns/1ps
module gpp_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   if (WIDTH < 1)
   begin : g_width_bad
      $error("gpp_sync width must be positive");
   end

   // first stage is read only by the second stage
   always_comb
   begin
      meta_d = ce ? async_in : meta_q;
      sync_d = ce ? meta_q : sync_q;
   end

   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (!rst_b)
         begin
            meta_q <= '0;
            sync_q <= '0;
         end
         else
         begin
            meta_q <= meta_d;
            sync_q <= sync_d;
         end
      end
   end

   assign sync_out = sync_q;

endmodule : gpp_sync

/* src/gpp_top.sv */
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// RL1: writes to pin level or latch register both update the one output latch
// RL2: latch read gives stored latch; pin level read gives sampled pin
// RL3: analog select set turns off that pin's digital input buffer
// RL4: after reset every pin is driven from the port latch
// RL5: analog inputs stay connected; digital outputs may drive analog pins
// RL6: enabled analog output forces the digital driver off
// RL7: peripheral owned pin ignores latch but stays readable
// RL8: each pull-up bit enables its pin's weak pull-up
// RL9: pull-up is dropped whenever the pin is an output
// RL10: open-drain bit makes the pin sink-only, else push-pull
// RL11: unimplemented open-drain, latch, analog bits read zero
// RL12: unimplemented direction bit reads one
// RL13: direction one is input, zero drives the latch value out
// RL14: direction still rules analog pins; analog pins read zero
// RL15: software keeps direction set on analog input pins
// RL16: slew bit set limits the edge rate, clear gives full rate
// RL17: threshold bit picks schmitt cmos or ttl for reads and change detect
// RL18: software changes thresholds only with peripherals disabled
// RL19: i2c ownership forces open-drain without the open-drain bit
// RL20: each port holds its own independent eight-bit control fields
module gpp_top #(
   parameter int ADDR_W = 12
) (
   input  wire logic                                     clk,
   input  wire logic                                     rst_b,
   input  wire logic                                     ce,
   input  wire logic                                     psel,
   input  wire logic                                     penable,
   input  wire logic                                     pwrite,
   input  wire logic [ADDR_W-1:0]                        paddr,
   input  wire logic [31:0]                              pwdata,
   output logic      [31:0]                              prdata,
   output logic                                          pready,
   output logic                                          pslverr,
   input  wire logic [gpp_pkg::NUM_PORTS-1:0][7:0]       pin_in,
   input  wire gpp_pkg::gpp_periph_type [gpp_pkg::NUM_PORTS-1:0] periph,
   output gpp_pkg::gpp_pad_type [gpp_pkg::NUM_PORTS-1:0] pad,
   output logic      [gpp_pkg::NUM_PORTS-1:0][7:0]       dig_in
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (ADDR_W < gpp_pkg::PORT_SEL_BIT + 1)
   begin : g_addr_narrow
      $error("gpp_top address too narrow for the register map");
   end
   if (ADDR_W > 32)
   begin : g_addr_wide
      $error("gpp_top address wider than the bus allows");
   end
   // the implemented-bit masks and the byte lane hold two 8-bit ports
   if ((gpp_pkg::NUM_PORTS != 2) || (gpp_pkg::PORT_W != 8))
   begin : g_geometry
      $error("gpp_top geometry does not match the bit masks");
   end
   // the register index sits in address bits 5:2 below the port bit
   if (gpp_pkg::PORT_SEL_BIT < 6)
   begin : g_port_bit
      $error("gpp_top port select overlaps the register index");
   end

   // ****************************************************************
   // declarations
   // ****************************************************************
   gpp_pkg::gpp_ctrl_type [gpp_pkg::NUM_PORTS-1:0] ctrl_q;
   gpp_pkg::gpp_ctrl_type [gpp_pkg::NUM_PORTS-1:0] ctrl_d;
   gpp_pkg::gpp_pad_type  [gpp_pkg::NUM_PORTS-1:0] pad_q;
   gpp_pkg::gpp_pad_type  [gpp_pkg::NUM_PORTS-1:0] pad_d;
   logic [gpp_pkg::NUM_PORTS-1:0][7:0]             dig_in_q;
   logic [gpp_pkg::NUM_PORTS-1:0][7:0]             dig_in_d;
   logic [gpp_pkg::NUM_PORTS-1:0][7:0]             pin_sync;
   logic [gpp_pkg::NUM_PORTS-1:0][7:0]             pin_level;
   logic [31:0]                                    prdata_q;
   logic [31:0]                                    prdata_d;
   logic                                           port_idx;
   logic [3:0]                                     reg_idx;
   logic                                           addr_hit;
   logic                                           rd_take;
   logic                                           rd_held_q;
   logic                                           rd_held_d;
   logic                                           wr_take;
   logic [7:0]                                     wbyte;
   logic [7:0]                                     rd_byte;

   // ****************************************************************
   // pin input synchroniser
   // ****************************************************************
   gpp_sync #(
      .WIDTH    (gpp_pkg::NUM_PORTS * gpp_pkg::PORT_W)
   ) u_pin_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // ****************************************************************
   // address decode
   // ****************************************************************
   // the map is sparse on purpose: port select is one address bit,
   // so every upper bit must be zero for a hit
   always_comb
   begin
      port_idx = paddr[gpp_pkg::PORT_SEL_BIT];
      reg_idx  = paddr[5:2];
      addr_hit = (reg_idx <= gpp_pkg::IDX_PERIPH_SEL)
                 && (paddr[1:0] == 2'h0)
                 && ((paddr >> (gpp_pkg::PORT_SEL_BIT + 1)) == '0);
      wr_take  = ce && psel && penable && pwrite && addr_hit;
      wbyte    = pwdata[7:0];
   end

   // a frozen block stalls the bus rather than dropping the access; a
   // read also waits until its data sits in the flop, so a freeze over
   // the setup edge costs a wait state instead of returning stale data
   assign pready  = ce && !(psel && penable && !pwrite && !rd_held_q);
   assign pslverr = psel && penable && !addr_hit;

   // ****************************************************************
   // pin level view
   // ****************************************************************
   always_comb
   begin
      for (int p = 0; p < gpp_pkg::NUM_PORTS; p++)
      begin
         // analog pins have no input buffer and so read as zero
         pin_level[p] = pin_sync[p] & ~ctrl_q[p].analog_sel; // RL3 RL14
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   always_comb
   begin
      ctrl_d = ctrl_q;
      for (int p = 0; p < gpp_pkg::NUM_PORTS; p++)
      begin
         if (wr_take && (port_idx == p[0])) // RL20
         begin
            case (reg_idx)
               gpp_pkg::IDX_PIN_LEVEL,
               gpp_pkg::IDX_OUT_LATCH:
                  ctrl_d[p].out_latch =
                     wbyte & gpp_pkg::IMPL_MASK[p]; // RL1 RL11
               gpp_pkg::IDX_DIRECTION:
                  ctrl_d[p].direction =
                     wbyte | gpp_pkg::DIR_FILL[p]; // RL12
               gpp_pkg::IDX_ANALOG_SEL:
                  ctrl_d[p].analog_sel =
                     wbyte & gpp_pkg::IMPL_MASK[p]; // RL11
               gpp_pkg::IDX_PULLUP_EN:
                  ctrl_d[p].pullup_en =
                     wbyte & gpp_pkg::FULL_MASK[p];
               gpp_pkg::IDX_OPEN_DRAIN:
                  ctrl_d[p].open_drain =
                     wbyte & gpp_pkg::IMPL_MASK[p]; // RL11
               gpp_pkg::IDX_SLEW_LIMIT:
                  ctrl_d[p].slew_limit =
                     wbyte & gpp_pkg::IMPL_MASK[p];
               gpp_pkg::IDX_IN_THRESH:
                  ctrl_d[p].in_thresh =
                     wbyte & gpp_pkg::FULL_MASK[p];
               gpp_pkg::IDX_PERIPH_SEL:
                  ctrl_d[p].periph_sel =
                     wbyte & gpp_pkg::IMPL_MASK[p];
               default:
                  ctrl_d[p] = ctrl_q[p];
            endcase
         end
      end
   end

   // reset waits for the enable as well, so a frozen block keeps every
   // bit; reset must therefore span at least one enabled edge
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (!rst_b)
         begin
            for (int p = 0; p < gpp_pkg::NUM_PORTS; p++)
            begin
               ctrl_q[p].out_latch  <= gpp_pkg::RST_OUT_LATCH;
               ctrl_q[p].direction  <= gpp_pkg::RST_DIRECTION;
               ctrl_q[p].analog_sel <= gpp_pkg::RST_ANALOG_SEL
                                       & gpp_pkg::IMPL_MASK[p];
               ctrl_q[p].pullup_en  <= gpp_pkg::RST_PULLUP_EN;
               ctrl_q[p].open_drain <= gpp_pkg::RST_OPEN_DRAIN;
               ctrl_q[p].slew_limit <= gpp_pkg::RST_SLEW_LIMIT
                                       & gpp_pkg::IMPL_MASK[p];
               ctrl_q[p].in_thresh  <= gpp_pkg::RST_IN_THRESH;
               ctrl_q[p].periph_sel <= gpp_pkg::RST_PERIPH_SEL; // RL4
            end
         end
         else
         begin
            ctrl_q <= ctrl_d;
         end
      end
   end

   // ****************************************************************
   // register read
   // ****************************************************************
   always_comb
   begin
      rd_byte = 8'h00;
      case (reg_idx)
         gpp_pkg::IDX_PIN_LEVEL:
            rd_byte = pin_level[port_idx]; // RL2 RL7
         gpp_pkg::IDX_DIRECTION:
            rd_byte = ctrl_q[port_idx].direction;
         gpp_pkg::IDX_OUT_LATCH:
            rd_byte = ctrl_q[port_idx].out_latch; // RL2
         gpp_pkg::IDX_ANALOG_SEL:
            rd_byte = ctrl_q[port_idx].analog_sel;
         gpp_pkg::IDX_PULLUP_EN:
            rd_byte = ctrl_q[port_idx].pullup_en;
         gpp_pkg::IDX_OPEN_DRAIN:
            rd_byte = ctrl_q[port_idx].open_drain;
         gpp_pkg::IDX_SLEW_LIMIT:
            rd_byte = ctrl_q[port_idx].slew_limit;
         gpp_pkg::IDX_IN_THRESH:
            rd_byte = ctrl_q[port_idx].in_thresh;
         gpp_pkg::IDX_PERIPH_SEL:
            rd_byte = ctrl_q[port_idx].periph_sel;
         default:
            rd_byte = 8'h00;
      endcase
   end

   // ****************************************************************
   // read data capture
   // ****************************************************************
   // a read takes the register once, in its first enabled cycle, and
   // holds it in the flop until the access phase completes; the sample
   // is one cycle old
   always_comb
   begin
      rd_take   = psel && !pwrite && !rd_held_q;
      prdata_d  = prdata_q;
      rd_held_d = rd_held_q;
      if (rd_take)
      begin
         prdata_d  = addr_hit ? {24'h000000, rd_byte} : 32'h00000000;
         rd_held_d = 1'b1;
      end
      if (psel && penable && rd_held_q)
      begin
         rd_held_d = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (!rst_b)
         begin
            prdata_q  <= 32'h00000000;
            rd_held_q <= 1'b0;
         end
         else
         begin
            prdata_q  <= prdata_d;
            rd_held_q <= rd_held_d;
         end
      end
   end

   assign prdata = prdata_q;

   // ****************************************************************
   // pad drive
   // ****************************************************************
   always_comb
   begin
      for (int p = 0; p < gpp_pkg::NUM_PORTS; p++)
      begin : pad_logic
         logic [7:0] value;
         logic [7:0] drv_on;
         logic [7:0] sink_only;
         value     = 8'h00;
         drv_on    = 8'h00;
         sink_only = 8'h00;
         // peripheral selection takes the pin away from the latch
         value = (ctrl_q[p].periph_sel & periph[p].drive)
                 | (~ctrl_q[p].periph_sel
                    & ctrl_q[p].out_latch); // RL7 RL4
         // analog select is not looked at here, so digital outputs
         // keep driving analog pins
         drv_on = ~ctrl_q[p].direction // RL13 RL14 RL5
                  & ~periph[p].analog_out_en; // RL6
         sink_only = ctrl_q[p].open_drain // RL10
                     | (ctrl_q[p].periph_sel
                        & periph[p].i2c_mode); // RL19
         pad_d[p].out          = value;
         pad_d[p].oe           = drv_on & (~sink_only | ~value); // RL10
         pad_d[p].pullup_on    = ctrl_q[p].pullup_en // RL8
                                 & ctrl_q[p].direction; // RL9
         pad_d[p].slew_limited = ctrl_q[p].slew_limit; // RL16
         pad_d[p].ttl_select   = ctrl_q[p].in_thresh; // RL17
         pad_d[p].in_buf_en    = ~ctrl_q[p].analog_sel; // RL3
         dig_in_d[p]           = pin_level[p]; // RL3
      end
   end

   // pads come out of reset released: no driver and no pull-up
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (!rst_b)
         begin
            for (int p = 0; p < gpp_pkg::NUM_PORTS; p++)
            begin
               pad_q[p].out          <= gpp_pkg::RST_OUT_LATCH;
               pad_q[p].oe           <= 8'h00;
               pad_q[p].pullup_on    <= gpp_pkg::RST_PULLUP_EN;
               pad_q[p].slew_limited <= gpp_pkg::RST_SLEW_LIMIT
                                        & gpp_pkg::IMPL_MASK[p];
               pad_q[p].ttl_select   <= gpp_pkg::RST_IN_THRESH;
               pad_q[p].in_buf_en    <= ~(gpp_pkg::RST_ANALOG_SEL
                                          & gpp_pkg::IMPL_MASK[p]);
               dig_in_q[p]           <= 8'h00;
            end
         end
         else
         begin
            pad_q    <= pad_d;
            dig_in_q <= dig_in_d;
         end
      end
   end

   assign pad    = pad_q;
   assign dig_in = dig_in_q;

endmodule : gpp_top

/* tb/gpio_port_pin_control_test.sv */
`timescale 1ns/1ps
// ****************************************************************
// register and pad walk
// ****************************************************************
module gpio_port_pin_control_test;
   logic                          clk = 1'b0;
   logic                          rst_b = 1'b0;
   logic                          ce = 1'b1;
   logic                          psel = 1'b0;
   logic                          penable = 1'b0;
   logic                          pwrite = 1'b0;
   logic [11:0]                   paddr = 12'h000;
   logic [31:0]                   pwdata = 32'h0;
   logic [31:0]                   prdata;
   logic                          pready;
   logic                          pslverr;
   logic [1:0][7:0]               pin_in;
   gpp_pkg::gpp_periph_type [1:0] periph = 48'h0;
   gpp_pkg::gpp_pad_type [1:0]    pad;
   logic [1:0][7:0]               dig_in;
   logic [1:0][7:0]               ext_en = 16'hFFFF;
   logic [1:0][7:0]               ext_lvl = 16'h0000;
   int                            fail_count = 0;
   int                            check_count = 0;
   int                            cyc = 0;
   logic [31:0]                   rd_q;
   logic                          err_q;
   logic [7:0]                    rv [1:8] = '{gpp_pkg::RST_DIRECTION,
      gpp_pkg::RST_OUT_LATCH, gpp_pkg::RST_ANALOG_SEL, gpp_pkg::RST_PULLUP_EN,
      gpp_pkg::RST_OPEN_DRAIN, gpp_pkg::RST_SLEW_LIMIT,
      gpp_pkg::RST_IN_THRESH, gpp_pkg::RST_PERIPH_SEL};

   always #12.5 clk = ~clk;

   gpp_top gpp_top_i (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .periph(periph), .pad(pad), .dig_in(dig_in));
   gpp_pins_model gpp_pins_model_i (.clk(clk), .pad(pad), .ext_en(ext_en),
      .ext_lvl(ext_lvl), .pin_in(pin_in));

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   // a hang ends in the same report
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         fail_count++;
         summarize();
      end
   end

   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected read at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk_rd

   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected pad at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk_pin

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input int p, input logic [3:0] i, input logic [7:0] d);
      apb(1'b1, 12'(p * 64 + i * 4), {24'h000000, d});
   endtask : wr

   task automatic rd(input int p, input logic [3:0] i, input logic [7:0] e);
      apb(1'b0, 12'(p * 64 + i * 4), 32'h0);
      chk_rd(rd_q, {24'h000000, e});
   endtask : rd

   // pads lag one edge, pin reads three; four covers both
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask : settle

   function automatic logic [7:0] imp(input int p, input logic [3:0] i);
      if (i == gpp_pkg::IDX_PULLUP_EN || i == gpp_pkg::IDX_IN_THRESH)
         return gpp_pkg::FULL_MASK[p];
      return gpp_pkg::IMPL_MASK[p];
   endfunction : imp

   function automatic logic [7:0] fill(input int p, input logic [3:0] i);
      return (i == gpp_pkg::IDX_DIRECTION) ? gpp_pkg::DIR_FILL[p] : 8'h00;
   endfunction : fill

   task automatic reset_regs(input int p);
      for (int i = 1; i <= 8; i++)
         rd(p, 4'(i), rv[i] & imp(p, 4'(i)) | fill(p, 4'(i)));
   endtask : reset_regs

   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      reset_regs(0);
      rd(0, gpp_pkg::IDX_PIN_LEVEL, 8'h00);
      chk_pin(pad[0].oe | pad[1].oe, 8'h00);
      for (int i = 1; i <= 8; i++)
      begin
         wr(0, 4'(i), 8'hFF);
         rd(0, 4'(i), imp(0, 4'(i)) | fill(0, 4'(i)));
         wr(0, 4'(i), 8'h00);
         rd(0, 4'(i), fill(0, 4'(i)));
      end
      reset_regs(1);
      wr(0, gpp_pkg::IDX_PIN_LEVEL, 8'h5A);
      rd(0, gpp_pkg::IDX_OUT_LATCH, 8'h5A);
      wr(0, gpp_pkg::IDX_OUT_LATCH, 8'hC3);
      rd(0, gpp_pkg::IDX_OUT_LATCH, 8'hC3);
      ext_en[1] <= 8'hF0;
      ext_lvl[1] <= 8'h30;
      wr(1, gpp_pkg::IDX_ANALOG_SEL, 8'h00);
      wr(1, gpp_pkg::IDX_DIRECTION, 8'hF0);
      wr(1, gpp_pkg::IDX_OUT_LATCH, 8'hA5);
      wr(1, gpp_pkg::IDX_PULLUP_EN, 8'hFF);
      settle();
      chk_pin(pad[1].oe, 8'h0F);
      chk_pin(pad[1].out, 8'hA5);
      chk_pin(pad[1].pullup_on, 8'hF0);
      chk_pin(dig_in[1], 8'h35);
      rd(1, gpp_pkg::IDX_PIN_LEVEL, 8'h35);
      rd(1, gpp_pkg::IDX_OUT_LATCH, 8'hA5);
      wr(1, gpp_pkg::IDX_OPEN_DRAIN, 8'h0F);
      settle();
      chk_pin(pad[1].oe, 8'h0A);
      @(posedge clk);
      periph[1].analog_out_en <= 8'h03;
      settle();
      chk_pin(pad[1].oe, 8'h08);
      @(posedge clk);
      periph[1] <= {8'h0F, 8'h0C, 8'h00};
      ext_en[1] <= 8'hFC;
      ext_lvl[1] <= 8'h3C;
      wr(1, gpp_pkg::IDX_OPEN_DRAIN, 8'h00);
      wr(1, gpp_pkg::IDX_PERIPH_SEL, 8'h0F);
      settle();
      chk_pin(pad[1].out, 8'hAF);
      chk_pin(pad[1].oe, 8'h03);
      rd(1, gpp_pkg::IDX_PIN_LEVEL, 8'h3F);
      rd(1, gpp_pkg::IDX_OUT_LATCH, 8'hA5);
      wr(1, gpp_pkg::IDX_ANALOG_SEL, 8'hFF);
      settle();
      chk_pin(dig_in[1] | pad[1].in_buf_en, 8'h00);
      chk_pin(pad[1].oe, 8'h03);
      rd(1, gpp_pkg::IDX_PIN_LEVEL, 8'h00);
      periph[1] <= '0;
      wr(1, gpp_pkg::IDX_PERIPH_SEL, 8'h00);
      wr(1, gpp_pkg::IDX_DIRECTION, 8'hFF);
      wr(1, gpp_pkg::IDX_SLEW_LIMIT, 8'h55);
      wr(1, gpp_pkg::IDX_IN_THRESH, 8'hA3);
      settle();
      chk_pin(pad[1].slew_limited, 8'h55);
      chk_pin(pad[1].ttl_select, 8'hA3);
      chk_pin(pad[1].oe, 8'h00);
      chk_pin(pad[1].pullup_on, 8'hFF);
      apb(1'b0, 12'h024, 32'h0);
      chk_rd({rd_q[30:0], err_q}, 32'h1);
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      settle();
      summarize();
   end
endmodule : gpio_port_pin_control_test

/* tb/gpp_pins_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// pins and the circuitry beyond them
// ****************************************************************
module gpp_pins_model (
   input  wire logic                       clk,
   input  wire gpp_pkg::gpp_pad_type [1:0] pad,
   input  wire logic [1:0][7:0]            ext_en,
   input  wire logic [1:0][7:0]            ext_lvl,
   output logic [1:0][7:0]                 pin_in
);
   // an undriven line with no pull-up toggles so a stale level never passes for a read
   logic [1:0][7:0] flt_q = 16'h5A5A;

   always @(posedge clk)
   begin
      flt_q <= ~flt_q;
   end

   always_comb
   begin
      for (int p = 0; p < 2; p++)
         pin_in[p] = (pad[p].oe & pad[p].out) | (~pad[p].oe
            & ((ext_en[p] & ext_lvl[p])
            | (~ext_en[p] & (pad[p].pullup_on | flt_q[p]))));
   end
endmodule : gpp_pins_model

/* tb/gpp_top_chk.sv */
`timescale 1ns/1ps
// ****************************************************************
// bus and pad invariants
// ****************************************************************
module gpp_top_chk (
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic                          ce,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   prdata,
   input  wire logic                          pready,
   input  wire logic                          pslverr,
   input  wire logic [1:0][7:0]               pin_in,
   input  wire gpp_pkg::gpp_periph_type [1:0] periph,
   input  wire gpp_pkg::gpp_pad_type [1:0]    pad,
   input  wire logic [1:0][7:0]               dig_in
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_analog_out_wins: assert property (
      ce |=> ((pad[0].oe & $past(periph[0].analog_out_en))
         | (pad[1].oe & $past(periph[1].analog_out_en))) == 8'h00)
      else $error("driver on under analog output");
   a_pullup_out_excl: assert property (
      ((pad[0].pullup_on & pad[0].oe) | (pad[1].pullup_on & pad[1].oe))
         == 8'h00)
      else $error("pull-up on a driven pin");
   a_dig_in_path: assert property (
      ce [*4] |-> dig_in == ($past(pin_in, 3)
         & {pad[1].in_buf_en, pad[0].in_buf_en}))
      else $error("digital input path wrong");
   a_reset_pads_idle: assert property (
      disable iff (1'b0) !rst_b && ce |=>
         (pad[0].oe | pad[1].oe | pad[0].out | pad[1].out) == 8'h00)
      else $error("pads active after reset");
   a_read_upper_zero: assert property (
      psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_slverr_access: assert property (
      pslverr |-> psel && penable)
      else $error("error outside access phase");
   a_ready_ce: assert property (
      !(psel && penable && !pwrite) |-> pready == ce)
      else $error("ready differs from enable");
   a_ready_read: assert property (
      psel && !penable && !pwrite && ce |=> pready == ce)
      else $error("read not answered after its setup");
   a_ready_frozen: assert property (pready |-> ce)
      else $error("ready while frozen");
   a_ce_freeze: assert property (
      !ce |=> $stable(pad) && $stable(dig_in) && $stable(prdata))
      else $error("state moved while frozen");
endmodule : gpp_top_chk

bind gpp_top gpp_top_chk gpp_top_chk_i (.clk(clk), .rst_b(rst_b), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .periph(periph),
   .pad(pad), .dig_in(dig_in));
